// File: design/eid_detect.sv
/*
 * External interrupt detection: NMI edge detection with blanking after
 * an edge-select change, eight IRQ inputs with edge or level sensing and
 * optional level hold, request flags, CPU priority mask and an APB slave.
 * Assumes pins are asynchronous; CPU events arrive on pclk.
 */
module eid_detect
    import eid_pkg::*;
#(
    parameter int N_IRQ = 8
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // External pins
    input  wire eid_pins_t    pins,
    // CPU core
    input  wire eid_cpu_evt_t cpu_evt,
    output logic [3:0]        cpu_priority_mask,
    output logic [N_IRQ-1:0]  irq_request_flags,
    output logic              nmi_request,
    output logic              irq_out
);

    // Elaboration check: flag register and read path are eight bits wide
    if (N_IRQ != 8) begin : g_bad_n_irq
        $error("eid_detect serves exactly eight IRQ inputs");
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    eid_pins_t pins_s1_reg;
    eid_pins_t pins_s2_reg;
    eid_pins_t pins_d_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
            pins_d_reg  <= '0;
        end else begin
            pins_s1_reg <= pins;
            pins_s2_reg <= pins_s1_reg;
            pins_d_reg  <= pins_s2_reg;
        end
    end

    // ==========================================================
    // APB decode
    // ==========================================================
    logic [31:0] ctrl0_reg;
    logic [31:0] ctrl1_reg;
    logic [31:0] cpu_operating_mode_reg_reg;
    logic        exc_block_reg;
    logic [1:0]  int_stat_reg;
    logic [1:0]  int_en_reg;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    function automatic logic eid_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : eid_hit

    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = eid_hit(paddr, EID_OFF_CTRL0) || eid_hit(paddr, EID_OFF_CTRL1)
                  || eid_hit(paddr, EID_OFF_REQ) || eid_hit(paddr, EID_OFF_MSKSET)
                  || eid_hit(paddr, EID_OFF_CPU_OPERATING_MODE_REG) || eid_hit(paddr, EID_OFF_CPUSTAT)
                  || eid_hit(paddr, EID_OFF_INTSTAT) || eid_hit(paddr, EID_OFF_INTCLR)
                  || eid_hit(paddr, EID_OFF_INTEN);

    // Zero wait states: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // ==========================================================
    // Control registers
    // ==========================================================
    logic nmi_edge_select;
    logic level_hold_select;
    logic [N_IRQ-1:0] irq_sense_select;
    logic auto_mask_update;

    assign nmi_edge_select   = ctrl0_reg[EID_C0_NMI_EDGE];
    assign level_hold_select = ctrl0_reg[EID_C0_LVL_HOLD];
    assign irq_sense_select  = ctrl1_reg[N_IRQ-1:0];
    assign auto_mask_update  = cpu_operating_mode_reg_reg[EID_OPM_AUTO_MSK];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg  <= EID_RST_CTRL0;
            ctrl1_reg  <= EID_RST_CTRL1;
            cpu_operating_mode_reg_reg <= EID_RST_CPU_OPERATING_MODE_REG;
        end else if (wr_en) begin
            if (eid_hit(paddr, EID_OFF_CTRL0)) begin
                // Bit 0 is the live NMI level, not storage
                ctrl0_reg <= {pwdata[31:1], 1'b0};
            end else if (eid_hit(paddr, EID_OFF_CTRL1)) begin
                ctrl1_reg <= {24'h000000, pwdata[7:0]};
            end else if (eid_hit(paddr, EID_OFF_CPU_OPERATING_MODE_REG)) begin
                cpu_operating_mode_reg_reg <= {31'h0000_0000, pwdata[EID_OPM_AUTO_MSK]};
            end
        end
    end

    // ==========================================================
    // NMI detection with blanking
    // ==========================================================
    logic [2:0] nmi_blank_reg;
    logic       nmi_edge;
    logic       edge_sel_wr;

    assign edge_sel_wr = wr_en && eid_hit(paddr, EID_OFF_CTRL0)
                      && (pwdata[EID_C0_NMI_EDGE] != nmi_edge_select);
    assign nmi_edge = nmi_edge_select ? (pins_s2_reg.nmi && !pins_d_reg.nmi)
                                      : (!pins_s2_reg.nmi && pins_d_reg.nmi);

    // Blanking hides the false edge a polarity swap would otherwise make
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_blank_reg <= 3'h0;
        end else if (edge_sel_wr) begin
            nmi_blank_reg <= EID_NMI_BLANK_CYC;
        end else if (nmi_blank_reg != 3'h0) begin
            nmi_blank_reg <= nmi_blank_reg - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_request <= 1'b0;
        end else if (nmi_edge && nmi_blank_reg == 3'h0 && !edge_sel_wr) begin
            nmi_request <= 1'b1;
        end else if (cpu_evt.accept_nmi) begin
            nmi_request <= 1'b0;
        end
    end

    // ==========================================================
    // CPU priority mask and block bit
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_priority_mask <= EID_RST_PRIO;
            exc_block_reg     <= 1'b1;
        end else begin
            if (cpu_evt.accept_nmi && auto_mask_update) begin
                cpu_priority_mask <= EID_NMI_PRIO;
            end else if (wr_en && eid_hit(paddr, EID_OFF_CPUSTAT)) begin
                cpu_priority_mask <= pwdata[EID_SR_MASK_LSB +: 4];
            end
            // Accepting blocks and wins over a return, which unblocks; a CPUSTAT write counts only without either
            if (cpu_evt.accept) begin
                exc_block_reg <= 1'b1;
            end else if (cpu_evt.ret_exception) begin
                exc_block_reg <= 1'b0;
            end else if (wr_en && eid_hit(paddr, EID_OFF_CPUSTAT)) begin
                exc_block_reg <= pwdata[EID_SR_BLOCK];
            end
        end
    end

    // ==========================================================
    // IRQ request flags
    // ==========================================================
    logic [N_IRQ-1:0] irq_lvl;
    logic [N_IRQ-1:0] irq_rise;
    logic [N_IRQ-1:0] latch_reg;
    logic [N_IRQ-1:0] flags_next;
    logic [N_IRQ-1:0] flags_view;
    logic             req_wr;
    logic             msk_wr;

    // Requests are active low on the pins
    assign irq_lvl  = ~pins_s2_reg.irq;
    assign irq_rise = ~pins_s2_reg.irq & pins_d_reg.irq;
    assign req_wr   = wr_en && eid_hit(paddr, EID_OFF_REQ);
    assign msk_wr   = wr_en && eid_hit(paddr, EID_OFF_MSKSET);

    // Level-hold inputs show the synchronised pin, all others the held flag
    assign flags_view = (irq_sense_select & {N_IRQ{level_hold_select}} & irq_lvl)
                      | (~(irq_sense_select & {N_IRQ{level_hold_select}}) & flags_next);

    always_comb begin
        flags_next = latch_reg;
        for (int i = 0; i < N_IRQ; i++) begin
            if (irq_sense_select[i]) begin
                if (level_hold_select) begin
                    flags_next[i] = 1'b0;
                end else if (irq_lvl[i]) begin
                    flags_next[i] = 1'b1;
                end else if (cpu_evt.accept || (msk_wr && pwdata[i])) begin
                    flags_next[i] = 1'b0;
                end
            end else begin
                if (req_wr && !pwdata[i]) begin
                    flags_next[i] = 1'b0;
                end
                if (irq_rise[i]) begin
                    flags_next[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= flags_next;
        end
    end

    // Level-hold mode shows level-sensed pins straight through; edge inputs keep their flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request_flags <= '0;
        end else begin
            irq_request_flags <= flags_view;
        end
    end

    // ==========================================================
    // Interrupt status, enable and output
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= 2'h0;
            int_en_reg   <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (wr_en && eid_hit(paddr, EID_OFF_INTCLR) && pwdata[b]) begin
                    int_stat_reg[b] <= 1'b0;
                end
            end
            // Set wins over clear
            if (nmi_edge && nmi_blank_reg == 3'h0 && !edge_sel_wr) begin
                int_stat_reg[EID_IS_NMI] <= 1'b1;
            end
            // Level-hold requests must reach the status bit as well
            if (|flags_view) begin
                int_stat_reg[EID_IS_IRQ] <= 1'b1;
            end
            if (wr_en && eid_hit(paddr, EID_OFF_INTEN)) begin
                int_en_reg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(int_stat_reg & int_en_reg);
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (eid_hit(paddr, EID_OFF_CTRL0)) begin
                prdata <= {ctrl0_reg[31:1], pins_s2_reg.nmi};
            end else if (eid_hit(paddr, EID_OFF_CTRL1)) begin
                prdata <= ctrl1_reg;
            end else if (eid_hit(paddr, EID_OFF_REQ)) begin
                prdata <= {24'h000000, irq_request_flags};
            end else if (eid_hit(paddr, EID_OFF_CPU_OPERATING_MODE_REG)) begin
                prdata <= cpu_operating_mode_reg_reg;
            end else if (eid_hit(paddr, EID_OFF_CPUSTAT)) begin
                prdata <= {3'h0, exc_block_reg, 20'h00000, cpu_priority_mask, 4'h0};
            end else if (eid_hit(paddr, EID_OFF_INTSTAT)) begin
                prdata <= {30'h0000_0000, int_stat_reg};
            end else if (eid_hit(paddr, EID_OFF_INTEN)) begin
                prdata <= {30'h0000_0000, int_en_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule : eid_detect

// File: common/eid_pkg.sv
/*
 * Package for the external interrupt detection block: register offsets,
 * field positions, reset values, timing counts and carrier structs.
 * Assumes a 10 MHz APB clock and 32-bit APB data.
 */
package eid_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] EID_OFF_CTRL0   = 8'h00;
    localparam logic [7:0] EID_OFF_CTRL1   = 8'h04;
    localparam logic [7:0] EID_OFF_REQ     = 8'h08;
    localparam logic [7:0] EID_OFF_MSKSET  = 8'h0c;
    localparam logic [7:0] EID_OFF_CPU_OPERATING_MODE_REG  = 8'h10;
    localparam logic [7:0] EID_OFF_CPUSTAT = 8'h14;
    localparam logic [7:0] EID_OFF_INTSTAT = 8'h18;
    localparam logic [7:0] EID_OFF_INTCLR  = 8'h1c;
    localparam logic [7:0] EID_OFF_INTEN   = 8'h20;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int EID_C0_NMI_LEVEL = 0;
    localparam int EID_C0_NMI_EDGE  = 1;
    localparam int EID_C0_LVL_HOLD  = 2;
    localparam int EID_C0_ENC_LSB   = 4;
    localparam int EID_C0_PORT_LSB  = 8;
    localparam int EID_OPM_AUTO_MSK = 0;
    localparam int EID_SR_MASK_LSB  = 4;
    localparam int EID_SR_BLOCK     = 28;
    localparam int EID_IS_NMI       = 0;
    localparam int EID_IS_IRQ       = 1;

    // ==========================================================
    // Reset values and constants
    // ==========================================================
    localparam logic [31:0] EID_RST_CTRL0   = 32'h0000_0000;
    localparam logic [31:0] EID_RST_CTRL1   = 32'h0000_0000;
    localparam logic [31:0] EID_RST_CPU_OPERATING_MODE_REG  = 32'h0000_0000;
    localparam logic [3:0]  EID_RST_PRIO    = 4'hf;
    localparam logic [3:0]  EID_NMI_PRIO    = 4'hf;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int EID_CLK_HZ          = 10_000_000;
    localparam int EID_NMI_BLANK_BCLK  = 6;
    localparam logic [2:0] EID_NMI_BLANK_CYC = 3'(EID_NMI_BLANK_BCLK);

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic       nmi;
        logic [7:0] irq;
        logic [3:0] enc_level;
        logic [7:0] port_irq;
    } eid_pins_t;

    typedef struct packed {
        logic       accept;
        logic       accept_nmi;
        logic       ret_exception;
    } eid_cpu_evt_t;

endpackage : eid_pkg

// File: tb/eid_detect_properties.sv
/*
 * Checker for eid_detect, bound to its ports.
 * Assumes APB writes land at the access edge with pready high.
 */
module eid_detect_properties
    import eid_pkg::*;
#(
    parameter int N_IRQ = 8
) (
    // Clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    // Pins and core
    input wire eid_pins_t          pins,
    input wire eid_cpu_evt_t       cpu_evt,
    input wire logic [3:0]         cpu_priority_mask,
    input wire logic [N_IRQ-1:0]   irq_request_flags,
    input wire logic               nmi_request
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Shadow of the control bits
    // ==========================================================
    logic             wr;
    logic             auto_q;
    logic             edge_q;
    logic             lh_q;
    logic [N_IRQ-1:0] sense_q;
    logic [3:0]       blank_q;
    assign wr = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_q  <= 1'b0;
            edge_q  <= 1'b0;
            lh_q    <= 1'b0;
            sense_q <= '0;
            blank_q <= 4'h0;
        end else begin
            if (wr && paddr == EID_OFF_CPU_OPERATING_MODE_REG) auto_q <= pwdata[EID_OPM_AUTO_MSK];
            if (wr && paddr == EID_OFF_CTRL1) sense_q <= pwdata[N_IRQ-1:0];
            if (wr && paddr == EID_OFF_CTRL0) begin
                edge_q <= pwdata[EID_C0_NMI_EDGE];
                lh_q   <= pwdata[EID_C0_LVL_HOLD];
            end
            // Margin over the blanking so a late edge is never judged
            if (wr && paddr == EID_OFF_CTRL0 && pwdata[EID_C0_NMI_EDGE] != edge_q) begin
                blank_q <= 4'ha;
            end else if (blank_q != 4'h0) begin
                blank_q <= blank_q - 4'h1;
            end
        end
    end
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access cycle without ready");
    chk_mask_auto: assert property (cpu_evt.accept_nmi && auto_q |=> cpu_priority_mask == 4'hf)
        else $error("mask not raised on nmi");
    chk_mask_kept: assert property (cpu_evt.accept_nmi && !auto_q && !wr |=> $stable(cpu_priority_mask))
        else $error("mask moved on nmi");
    chk_edge_held: assert property (!(wr && paddr == EID_OFF_REQ)
        |=> ($past(irq_request_flags) & ~$past(sense_q) & ~irq_request_flags) == '0)
        else $error("edge flag lost");
    chk_keep_ones: assert property (wr && paddr == EID_OFF_REQ |=> ($past(irq_request_flags)
        & $past(pwdata[N_IRQ-1:0]) & ~$past(sense_q) & ~irq_request_flags) == '0)
        else $error("flag cleared by one");
    chk_level_follow: assert property ((lh_q && (pins.irq & sense_q) == sense_q)[*5]
        |-> (irq_request_flags & sense_q) == '0)
        else $error("level flag stuck");
    chk_latch_held: assert property (!lh_q && !cpu_evt.accept && !wr
        |=> ($past(irq_request_flags) & $past(sense_q) & ~irq_request_flags) == '0)
        else $error("latched flag lost");
    chk_nmi_detect: assert property (edge_q && blank_q == 4'h0 && $rose(pins.nmi)
        ##1 (pins.nmi && !cpu_evt.accept_nmi)[*5] |-> nmi_request)
        else $error("nmi edge missed");
endmodule : eid_detect_properties

bind eid_detect eid_detect_properties #(.N_IRQ(N_IRQ)) i_props (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pready            (pready),
    .pins              (pins),
    .cpu_evt           (cpu_evt),
    .cpu_priority_mask (cpu_priority_mask),
    .irq_request_flags (irq_request_flags),
    .nmi_request       (nmi_request)
);

// File: tb/eid_src_model.sv
/*
 * Far side: interrupt sources and core event pulses.
 * Assumes the bench commands active high requests on pclk.
 */
module eid_src_model
    import eid_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Bench commands
    input  wire logic [7:0]   irq_cmd,
    input  wire logic         nmi_cmd,
    input  wire logic         keep,
    input  wire logic [11:0]  misc,
    input  wire eid_cpu_evt_t evt_cmd,
    // Toward the block
    output eid_pins_t         pins,
    output eid_cpu_evt_t      cpu_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_q <= '0;
        end else begin
            held_q <= keep ? (held_q | irq_cmd) & ~{8{cpu_evt.accept}} : 8'h00;
        end
    end
    // IRQ pins are active low
    // One driver per struct: fields in order nmi, irq, enc_level, port_irq
    assign pins = {nmi_cmd, ~(irq_cmd | held_q), misc[3:0], misc[11:4]};
    // An nmi acceptance is also an acceptance
    assign cpu_evt = {evt_cmd.accept | evt_cmd.accept_nmi, evt_cmd.accept_nmi,
                      evt_cmd.ret_exception};
endmodule : eid_src_model

// File: tb/external_irq_detect_bench.sv
/*
 * Bench for eid_detect with expected values kept in integers.
 * Assumes one 10 MHz clock and zero wait APB.
 */
module external_irq_detect_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import eid_pkg::*;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic         keep = 0, nmi_cmd = 0, pready, pslverr, nmi_request, irq_out, err;
    logic [7:0]   paddr = '0, irq_cmd = '0, irq_request_flags;
    logic [31:0]  pwdata = '0, prdata, rd, d;
    logic [3:0]   cpu_priority_mask;
    logic [11:0]  misc = '0;
    eid_pins_t    pins;
    eid_cpu_evt_t cpu_evt, evt_cmd = '0;
    int           fail_count = 0, total_checks = 0, cycles = 0, exp_flags;
    integer       seed = 57277;
    eid_detect #(.N_IRQ(8)) i_dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .pins              (pins),
        .cpu_evt           (cpu_evt),
        .cpu_priority_mask (cpu_priority_mask),
        .irq_request_flags (irq_request_flags),
        .nmi_request       (nmi_request),
        .irq_out           (irq_out)
    );
    eid_src_model i_src (
        .pclk    (pclk),
        .presetn (presetn),
        .irq_cmd (irq_cmd),
        .nmi_cmd (nmi_cmd),
        .keep    (keep),
        .misc    (misc),
        .evt_cmd (evt_cmd),
        .pins    (pins),
        .cpu_evt (cpu_evt)
    );
    always #50 pclk = ~pclk;
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic pulse(input eid_cpu_evt_t e);
        evt_cmd <= e;
        @(posedge pclk);
        evt_cmd <= '0;
        @(posedge pclk);
    endtask : pulse
    task automatic idle();
        repeat (6) @(posedge pclk);
    endtask : idle
    // Hang guard, far above the run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, EID_OFF_CTRL0, '0);
        chk(rd, 32'h0);
        apb(0, EID_OFF_CPUSTAT, '0);
        chk(rd & 32'h1000_00f0, 32'h1000_00f0);
        apb(0, 8'hfc, '0);
        chk({rd[30:0], err}, 32'h1);
        repeat (3) begin
            d = $random(seed);
            misc <= d[27:16];
            apb(1, EID_OFF_CTRL0, d);
            apb(0, EID_OFF_CTRL0, '0);
            chk(rd & 32'hfff7, d & 32'hfff6);
        end
        $display("Test reset and control done");
        apb(1, EID_OFF_CTRL0, 32'h0);
        apb(1, EID_OFF_CTRL1, 32'h0);
        irq_cmd <= 8'hff;
        idle();
        irq_cmd <= 8'h00;
        idle();
        exp_flags = 8'hff;
        chk(irq_request_flags, exp_flags);
        apb(1, EID_OFF_REQ, 32'h0f);
        exp_flags &= 8'h0f;
        chk(irq_request_flags, exp_flags);
        apb(1, EID_OFF_REQ, 32'hff);
        apb(0, EID_OFF_REQ, '0);
        chk(rd, exp_flags);
        apb(1, EID_OFF_REQ, 32'h0);
        chk(irq_request_flags, 8'h00);
        $display("Test edge flags done");
        apb(1, EID_OFF_CTRL0, 32'h4);
        apb(1, EID_OFF_CTRL1, 32'hff);
        apb(1, EID_OFF_INTCLR, 32'h2);
        irq_cmd <= 8'h5a;
        idle();
        chk(irq_request_flags, 8'h5a);
        apb(0, EID_OFF_INTSTAT, '0);
        chk(rd[1], 1'b1);
        irq_cmd <= 8'h00;
        idle();
        chk(irq_request_flags, 8'h00);
        keep <= 1'b1;
        irq_cmd <= 8'h81;
        idle();
        irq_cmd <= 8'h00;
        idle();
        chk(irq_request_flags, 8'h81);
        pulse(3'b100);
        idle();
        chk(irq_request_flags, 8'h00);
        keep <= 1'b0;
        $display("Test level follow done");
        apb(1, EID_OFF_CTRL0, 32'h0);
        irq_cmd <= 8'h3c;
        idle();
        pulse(3'b100);
        irq_cmd <= 8'h00;
        idle();
        chk(irq_request_flags, 8'h3c);
        apb(1, EID_OFF_MSKSET, 32'h0c);
        chk(irq_request_flags, 8'h30);
        pulse(3'b100);
        chk(irq_request_flags, 8'h00);
        apb(1, EID_OFF_REQ, 32'h0);
        pulse(3'b001);
        apb(0, EID_OFF_CPUSTAT, '0);
        chk(rd[28], 1'b0);
        $display("Test level latch done");
        apb(1, EID_OFF_CPU_OPERATING_MODE_REG, 32'h1);
        apb(1, EID_OFF_CPUSTAT, 32'h30);
        apb(1, EID_OFF_CTRL0, 32'h2);
        apb(1, EID_OFF_INTEN, 32'h1);
        idle();
        nmi_cmd <= 1'b1;
        idle();
        chk({nmi_request, irq_out}, 2'b11);
        apb(0, EID_OFF_CTRL0, '0);
        chk(rd[0], 1'b1);
        pulse(3'b110);
        chk(cpu_priority_mask, 4'hf);
        apb(1, EID_OFF_INTEN, 32'h0);
        // The interrupt output follows status and enable one cycle late
        @(posedge pclk);
        chk(irq_out, 1'b0);
        apb(1, EID_OFF_INTCLR, 32'h1);
        apb(0, EID_OFF_INTSTAT, '0);
        chk(rd[0], 1'b0);
        apb(1, EID_OFF_CPU_OPERATING_MODE_REG, 32'h0);
        apb(1, EID_OFF_CPUSTAT, 32'h30);
        nmi_cmd <= 1'b0;
        idle();
        chk(nmi_request, 1'b0);
        nmi_cmd <= 1'b1;
        idle();
        chk(nmi_request, 1'b1);
        pulse(3'b110);
        chk(cpu_priority_mask, 4'h3);
        $display("Test nmi done");
        complete_run();
    end
endmodule : external_irq_detect_bench
